// >>> hdl/svdr_hold_timer.sv
// persistence timer: reports a condition held without a break for LIMIT cycles
// assumes cond is synchronous to ref_clk; any low cycle restarts the count
`timescale 1ns/1ps
module svdr_hold_timer
  import svdr_pkg::*;
#(
  parameter int unsigned LIMIT = 16
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cond,
  output logic expired
);

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);
  localparam logic [CW-1:0] ZERO_C = '0;
  localparam logic [CW-1:0] ONE_C = CW'(1);

  generate
    if (LIMIT < 1)
    begin : g_bad
      $error("svdr_hold_timer LIMIT must be at least one");
    end
  endgenerate

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic next_expired;

  // count up while held, saturate at the limit, drop to zero on a break
  always_comb
  begin
    next_count = count;
    if (!cond)
      next_count = ZERO_C;
    else if (count != LIMIT_C)
      next_count = count + ONE_C;
    next_expired = cond && (next_count == LIMIT_C);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      count <= ZERO_C;
      expired <= 1'b0;
    end
    else
    begin
      count <= next_count;
      expired <= next_expired;
    end
  end

endmodule : svdr_hold_timer

// >>> hdl/svdr_pkg.sv
// servo drive steering and retract: shared constants, register map, types
// assumes a 125 MHz ref_clk and a 32-bit AXI4-Lite register bus
package svdr_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
  localparam int unsigned RETRACT_WAIT_MS = 640;
  localparam int unsigned OVERCURRENT_MS = 975;
  // longest times would round down; both divide exactly at this rate
  localparam int unsigned RETRACT_WAIT_CYC = RETRACT_WAIT_MS * CLK_PER_MS;
  localparam int unsigned OVERCURRENT_CYC = OVERCURRENT_MS * CLK_PER_MS;

  // bus geometry
  localparam int AXI_AW = 4;
  localparam int AXI_DW = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register byte offsets
  localparam logic [AXI_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AXI_AW-1:0] REG_STATUS = 4'h4;
  localparam logic [AXI_AW-1:0] REG_MASK = 4'h8;
  localparam logic [AXI_AW-1:0] REG_STATE = 4'hC;

  // control fields
  localparam int CTRL_VEL_BIT = 0;
  localparam int CTRL_EVEN_BIT = 1;
  localparam int CTRL_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

  // status and mask fields (same layout)
  localparam int EV_TIMEOUT = 0;
  localparam int EV_PWRFAULT = 1;
  localparam int EV_OVERCUR = 2;
  localparam int EV_SUPPLY = 3;
  localparam int EV_PARKED = 4;
  localparam int EV_W = 5;
  localparam logic [EV_W-1:0] EV_RESET = 5'h00;
  localparam logic [EV_W-1:0] MASK_RESET = 5'h00;

  // state register fields
  localparam int ST_RETRACT = 0;
  localparam int ST_DRIVE = 1;
  localparam int ST_UFWD = 2;
  localparam int ST_UREV = 3;
  localparam int ST_LFWD = 4;
  localparam int ST_LREV = 5;
  localparam int ST_CTAP = 6;
  localparam int ST_RELAY = 7;
  localparam int ST_W = 8;

  // operating modes of the bridge steering
  typedef enum logic [1:0] {
    SVDR_POSITION,
    SVDR_VELOCITY,
    SVDR_RETRACT
  } svdr_mode_t;

endpackage : svdr_pkg

// >>> hdl/svdr_steer.sv
// servo drive steering: voice coil bridge switch steering, emergency retract
// detection and sequencing, servo head polarity select, AXI4-Lite registers
// assumes all sensor inputs are already synchronous to ref_clk
//
// Contract
// RULE1: position mode: center tap plus one lower switch
// RULE2: lower switches clamped when retracting before upspeed
// RULE3: never both lower switches on together
// RULE4: velocity mode: no center tap, drive inputs choose
// RULE5: forward uses upper/lower forward, reverse likewise
// RULE6: retract if not parked 640 ms after request
// RULE7: retract whenever power fault clear asserted
// RULE8: retract after 975 ms unbroken overcurrent
// RULE9: retract on 50 V loss while not parked
// RULE10: retract switches relay and powers retract driver
// RULE11: retract driver off once heads are parked
// RULE12: retract driver toggled by speed comparator
// RULE13: head signal inverted per even cylinder select
// RULE14: error sign picks reverse, forward or none
// RULE15: only one direction path active
// RULE16: even select chooses even or odd nulls
// RULE17: retract latched until system reset
// RULE18: retract mode: bridge and center tap off
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module svdr_steer
  import svdr_pkg::*;
#(
  parameter int unsigned RETRACT_WAIT = RETRACT_WAIT_CYC,
  parameter int unsigned OVERCURRENT_WAIT = OVERCURRENT_CYC,
  parameter int HW = 12,
  parameter int EW = 12
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  // sensors and demands from the rest of the drive
  input wire logic retract_heads_request,
  input wire logic heads_retracted_switch,
  input wire logic forward_drive_n,
  input wire logic reverse_drive_n,
  input wire logic powerFaultClear,
  input wire logic coilOverCurrent,
  input wire logic supply50Ok,
  input wire logic spindleUpToSpeed,
  input wire logic retract_speed_sense,
  input wire logic signed [HW-1:0] headSignal,
  input wire logic signed [EW-1:0] positionError,
  // bridge, relay and retract driver
  output logic upperForward,
  output logic upperReverse,
  output logic lowerForward,
  output logic lowerReverse,
  output logic centerTap,
  output logic linear_forward_current,
  output logic linear_reverse_current,
  output logic retract_relay,
  output logic retractDrive,
  output logic signed [HW-1:0] headSignalOut,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam logic signed [HW-1:0] HEAD_MIN = {1'b1, {(HW-1){1'b0}}};
  localparam logic signed [HW-1:0] HEAD_MAX = {1'b0, {(HW-1){1'b1}}};
  localparam logic signed [EW-1:0] ERR_ZERO = '0;

  generate
    if (HW < 2 || EW < 2)
    begin : g_bad_width
      $error("svdr_steer signal widths must be at least two bits");
    end
  endgenerate

  // fault persistence timers
  logic requestTimedOut;
  logic overCurrentTimedOut;

  svdr_hold_timer #(
    .LIMIT(RETRACT_WAIT)
  ) u_request_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cond(retract_heads_request),
    .expired(requestTimedOut)
  );

  svdr_hold_timer #(
    .LIMIT(OVERCURRENT_WAIT)
  ) u_overcurrent_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cond(coilOverCurrent),
    .expired(overCurrentTimedOut)
  );

  // fault decode
  logic tripTimeout;
  logic tripPower;
  logic tripOverCurrent;
  logic tripSupply;
  logic anyTrip;

  assign tripTimeout = requestTimedOut && !heads_retracted_switch; // RULE6
  assign tripPower = powerFaultClear; // RULE7
  assign tripOverCurrent = overCurrentTimedOut; // RULE8
  assign tripSupply = !supply50Ok && !heads_retracted_switch; // RULE9
  assign anyTrip = tripTimeout || tripPower || tripOverCurrent || tripSupply;

  // register file state
  logic [CTRL_W-1:0] ctrl;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic [CTRL_W-1:0] next_ctrl;
  logic [EV_W-1:0] next_status;
  logic [EV_W-1:0] next_mask;

  // mode machine and bridge steering state
  svdr_mode_t mode;
  svdr_mode_t next_mode;
  logic parkedSeen;
  logic next_parkedSeen;
  logic next_upperForward;
  logic next_upperReverse;
  logic next_lowerForward;
  logic next_lowerReverse;
  logic next_centerTap;
  logic next_linFwd;
  logic next_linRev;
  logic next_relay;
  logic next_retractDrive;
  logic signed [HW-1:0] next_headSignalOut;
  logic velFwd;
  logic velRev;

  // mode: a trip overrides everything and only reset leaves retract
  always_comb
  begin
    next_mode = mode;
    case (mode)
      SVDR_POSITION, SVDR_VELOCITY:
      begin
        if (anyTrip)
          next_mode = SVDR_RETRACT; // RULE17
        else if (ctrl[CTRL_VEL_BIT])
          next_mode = SVDR_VELOCITY;
        else
          next_mode = SVDR_POSITION;
      end
      SVDR_RETRACT:
        next_mode = SVDR_RETRACT; // RULE17
      default:
        next_mode = SVDR_RETRACT;
    endcase
  end

  // velocity drive decode; both low at once is treated as no drive
  assign velFwd = !forward_drive_n && reverse_drive_n; // RULE4
  assign velRev = !reverse_drive_n && forward_drive_n; // RULE4

  // bridge steering from the next mode so outputs follow a trip at once
  always_comb
  begin
    next_upperForward = 1'b0;
    next_upperReverse = 1'b0;
    next_lowerForward = 1'b0;
    next_lowerReverse = 1'b0;
    next_centerTap = 1'b0;
    next_linFwd = 1'b0;
    next_linRev = 1'b0;
    next_relay = 1'b0;
    next_retractDrive = 1'b0;
    case (next_mode)
      SVDR_POSITION:
      begin
        // only one lower switch, picked by error sign, upper pair idle
        next_centerTap = 1'b1; // RULE1
        next_lowerForward = positionError > ERR_ZERO; // RULE14 RULE15
        next_lowerReverse = positionError < ERR_ZERO; // RULE14 RULE15
        next_linFwd = positionError > ERR_ZERO; // RULE14
        next_linRev = positionError < ERR_ZERO; // RULE14
      end
      SVDR_VELOCITY:
      begin
        // center tap stays off; diagonal pair per drive state
        next_upperForward = velFwd; // RULE5
        next_lowerForward = velFwd; // RULE5
        next_upperReverse = velRev; // RULE5
        next_lowerReverse = velRev; // RULE5
      end
      SVDR_RETRACT:
      begin
        // whole bridge dark, retract driver is the only source
        next_relay = 1'b1; // RULE10 RULE18
        // speed comparator chops the drive, parking switch kills it
        next_retractDrive = !heads_retracted_switch && !retract_speed_sense; // RULE11 RULE12
      end
      default:
      begin
        next_relay = 1'b1;
      end
    endcase
    // retract power before upspeed clamps both lower base drives
    if (next_mode == SVDR_RETRACT && !spindleUpToSpeed)
    begin
      next_lowerForward = 1'b0; // RULE2
      next_lowerReverse = 1'b0; // RULE2
    end
    // last guard against a supply short through both lower switches
    if (next_lowerForward && next_lowerReverse)
    begin
      next_lowerForward = 1'b0; // RULE3
      next_lowerReverse = 1'b0; // RULE3
    end
  end

  // track follower polarity; clip the one value that cannot be negated
  always_comb
  begin
    next_headSignalOut = headSignal;
    if (ctrl[CTRL_EVEN_BIT])
    begin
      if (headSignal == HEAD_MIN)
        next_headSignalOut = HEAD_MAX; // RULE13 RULE16
      else
        next_headSignalOut = -headSignal; // RULE13 RULE16
    end
  end

  // parked event fires once on the first park after a retract
  assign next_parkedSeen = parkedSeen || (mode == SVDR_RETRACT && heads_retracted_switch);

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      mode <= SVDR_POSITION;
      parkedSeen <= 1'b0;
      upperForward <= 1'b0;
      upperReverse <= 1'b0;
      lowerForward <= 1'b0;
      lowerReverse <= 1'b0;
      centerTap <= 1'b0;
      linear_forward_current <= 1'b0;
      linear_reverse_current <= 1'b0;
      retract_relay <= 1'b0;
      retractDrive <= 1'b0;
      headSignalOut <= '0;
    end
    else
    begin
      mode <= next_mode;
      parkedSeen <= next_parkedSeen;
      upperForward <= next_upperForward;
      upperReverse <= next_upperReverse;
      lowerForward <= next_lowerForward;
      lowerReverse <= next_lowerReverse;
      centerTap <= next_centerTap;
      linear_forward_current <= next_linFwd;
      linear_reverse_current <= next_linRev;
      retract_relay <= next_relay;
      retractDrive <= next_retractDrive;
      headSignalOut <= next_headSignalOut;
    end
  end

  // AXI4-Lite write path: address and data latched independently
  logic awHeld;
  logic wHeld;
  logic [AXI_AW-1:0] awAddr;
  logic [AXI_DW-1:0] wData;
  logic [3:0] wStrb;
  logic next_awHeld;
  logic next_wHeld;
  logic [AXI_AW-1:0] next_awAddr;
  logic [AXI_DW-1:0] next_wData;
  logic [3:0] next_wStrb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic doWrite;

  // read path
  logic next_rvalid;
  logic [AXI_DW-1:0] next_rdata;
  logic [1:0] next_rresp;
  logic doRead;
  logic [EV_W-1:0] events;
  logic [ST_W-1:0] stateWord;

  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign doRead = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddr = awAddr;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (doWrite)
    begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (awAddr == REG_CTRL || awAddr == REG_STATUS || awAddr == REG_MASK ||
                    awAddr == REG_STATE) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
  end

  // events and state word
  assign events = {parkedSeen ^ next_parkedSeen, tripSupply, tripOverCurrent, tripPower,
                   tripTimeout};
  assign stateWord = {retract_relay, centerTap, lowerReverse, lowerForward, upperReverse,
                      upperForward, retractDrive, mode == SVDR_RETRACT};

  // registers: set wins over the read clear of status
  always_comb
  begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_status = status;
    if (doRead && s_axi_araddr == REG_STATUS)
      next_status = EV_RESET;
    if (doWrite && wStrb[0])
    begin
      if (awAddr == REG_CTRL)
        next_ctrl = wData[CTRL_W-1:0];
      if (awAddr == REG_MASK)
        next_mask = wData[EV_W-1:0];
    end
    next_status = next_status | events;
  end

  // read answer one cycle after the address is taken
  always_comb
  begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (doRead)
    begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: next_rdata = AXI_DW'(ctrl);
        REG_STATUS: next_rdata = AXI_DW'(status);
        REG_MASK: next_rdata = AXI_DW'(mask);
        REG_STATE: next_rdata = AXI_DW'(stateWord);
        default:
        begin
          next_rdata = '0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      ctrl <= CTRL_RESET;
      mask <= MASK_RESET;
      status <= EV_RESET;
      irq <= 1'b0;
    end
    else
    begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddr <= next_awAddr;
      wData <= next_wData;
      wStrb <= next_wStrb;
      // ready only while the slot is free; one write in flight
      s_axi_awready <= !next_awHeld && !next_bvalid;
      s_axi_wready <= !next_wHeld && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      ctrl <= next_ctrl;
      mask <= next_mask;
      status <= next_status;
      irq <= |(next_status & next_mask);
    end
  end

endmodule : svdr_steer

// >>> sim/svdr_bridge_model.sv
// carriage model: retract travel, park switch and retract speed comparator
// assumes the steering block's relay and retract driver outputs, one clock
`timescale 1ns/1ps
module svdr_bridge_model
  import svdr_pkg::*;
#(
  parameter int unsigned TRAVEL = 12
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic retractDrive,
  input wire logic retract_relay,
  input wire logic unpark,
  output logic heads_retracted_switch,
  output logic retract_speed_sense
);
  logic [7:0] carriagePos;
  logic [7:0] next_carriagePos;
  logic speedHigh;
  logic next_speedHigh;

  // carriage moves back only while the relay routes the driver to the bobbin
  always_comb
  begin
    next_carriagePos = carriagePos;
    if (unpark)
      next_carriagePos = 8'(TRAVEL);
    else if (retractDrive && retract_relay && carriagePos != 8'h00)
      next_carriagePos = carriagePos - 8'h01;
    next_speedHigh = retractDrive && retract_relay; // speed lags the drive by one cycle
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      carriagePos <= 8'h00;
      speedHigh <= 1'b0;
    end
    else
    begin
      carriagePos <= next_carriagePos;
      speedHigh <= next_speedHigh;
    end
  end

  assign heads_retracted_switch = (carriagePos == 8'h00);
  assign retract_speed_sense = speedHigh;
endmodule : svdr_bridge_model

// >>> sim/svdr_steer_assertions.sv
// assertions on the bridge, relay and retract driver outputs of svdr_steer
// assumes binding into svdr_steer; sees only that module's ports
`timescale 1ns/1ps
module svdr_steer_assertions
  import svdr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic heads_retracted_switch,
  input wire logic powerFaultClear,
  input wire logic supply50Ok,
  input wire logic retract_speed_sense,
  input wire logic upperForward,
  input wire logic upperReverse,
  input wire logic lowerForward,
  input wire logic lowerReverse,
  input wire logic centerTap,
  input wire logic retract_relay,
  input wire logic retractDrive
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // bridge shape; a shorted supply is the worst hazard here
  lower_excl_a: assert property (!(lowerForward && lowerReverse))
    else $error("both lower switches on");
  center_upper_a: assert property (centerTap |-> !upperForward && !upperReverse)
    else $error("upper switch on with center tap");
  vel_pair_a: assert property ((upperForward || upperReverse) |->
    upperForward == lowerForward && upperReverse == lowerReverse && !centerTap)
    else $error("velocity switch pair broken");

  // trips and latch; bridge off on the same edge as the relay
  retract_quiet_a: assert property (retract_relay |->
    !(upperForward || upperReverse || lowerForward || lowerReverse || centerTap))
    else $error("bridge active during retract");
  retract_latch_a: assert property (retract_relay |=> retract_relay)
    else $error("retract latch released");
  fault_trip_a: assert property (powerFaultClear |=> retract_relay)
    else $error("power fault did not trip");
  supply_trip_a: assert property (!supply50Ok && !heads_retracted_switch |=> retract_relay)
    else $error("supply loss did not trip");

  // retract driver: speed comparator gating and park cut-off
  drive_on_a: assert property (retract_relay && !heads_retracted_switch
    && !retract_speed_sense |=> retractDrive)
    else $error("retract driver not on");
  drive_relay_a: assert property (retractDrive |-> retract_relay)
    else $error("retract driver without relay");
  drive_park_a: assert property (heads_retracted_switch |=> !retractDrive)
    else $error("retract driver on while parked");
  speed_gate_a: assert property (retract_speed_sense |=> !retractDrive)
    else $error("retract driver on above speed");

  trip_c: cover property ($rose(retract_relay));
  toggle_c: cover property (retract_relay && $fell(retractDrive));
  vel_c: cover property (upperReverse);
endmodule : svdr_steer_assertions

bind svdr_steer svdr_steer_assertions u_svdrChk (
  .ref_clk, .nrst, .heads_retracted_switch, .powerFaultClear, .supply50Ok,
  .retract_speed_sense, .upperForward, .upperReverse, .lowerForward, .lowerReverse,
  .centerTap, .retract_relay, .retractDrive
);

// >>> sim/svdr_steer_tb.sv
// bench for svdr_steer: steering, head polarity, retract trips, registers
// assumes svdr_bridge_model as the carriage and shortened timer parameters
`timescale 1ns/1ps
module svdr_steer_tb
  import svdr_pkg::*;
;
  localparam int unsigned RW = 20;
  localparam int unsigned OW = 30;
  localparam logic [11:0] CORNER [5] = '{12'h000, 12'h800, 12'h7FF, 12'h001, 12'hFFF};
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic retract_heads_request = 1'b0;
  logic forward_drive_n = 1'b1;
  logic reverse_drive_n = 1'b1;
  logic powerFaultClear = 1'b0;
  logic coilOverCurrent = 1'b0;
  logic supply50Ok = 1'b1;
  logic spindleUpToSpeed = 1'b1;
  logic unpark = 1'b0;
  logic signed [11:0] headSignal = 12'h000;
  logic signed [11:0] positionError = 12'h000;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic heads_retracted_switch, retract_speed_sense, upperForward, upperReverse;
  logic lowerForward, lowerReverse, centerTap, linear_forward_current;
  logic linear_reverse_current, retract_relay, retractDrive, irq, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic signed [11:0] headSignalOut;
  int errTotal = 0;
  int testsRun = 0;

  always #4 ref_clk = ~ref_clk;

  svdr_steer #(.RETRACT_WAIT(RW), .OVERCURRENT_WAIT(OW)) dut (.*);

  svdr_bridge_model car (.ref_clk, .nrst, .retractDrive, .retract_relay, .unpark,
    .heads_retracted_switch, .retract_speed_sense);

  // negation with the most negative code held at full scale
  function automatic logic signed [11:0] flipSig(input logic signed [11:0] v);
    return (v == 12'sh800) ? 12'sh7FF : -v;
  endfunction : flipSig

  // corner codes first, random codes after
  function automatic logic signed [11:0] pick(input int i);
    return (i < 5) ? CORNER[i] : 12'($urandom);
  endfunction : pick

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // address and data offered together, each released once taken
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 200);
    if (!s_axi_bvalid)
      errTotal++;
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 200);
    if (!s_axi_rvalid)
      errTotal++;
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axiRead

  task automatic regChk(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axiRead(a, d, r);
    check(what, d, exp);
    check(what, r, RESP_OKAY);
  endtask : regChk

  task automatic setCause(input int c, input logic v);
    case (c)
      0: retract_heads_request <= v;
      1: powerFaultClear <= v;
      2: coilOverCurrent <= v;
      default: supply50Ok <= !v;
    endcase
  endtask : setCause

  task automatic finishTest();
    $display("checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finishTest

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic signed [11:0] e;
    logic signed [11:0] h;
    logic fOn;
    logic rOn;
    int k;
    int n;
    void'($urandom(52769));
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    // reset values and an unaligned hole in the map
    regChk("ctrl", REG_CTRL, 32'h0);
    regChk("status", REG_STATUS, 32'h0);
    regChk("mask", REG_MASK, 32'h0);
    axiWrite(4'h2, 32'hFFFFFFFF, r);
    check("hole wresp", r, RESP_SLVERR);
    axiRead(4'h2, d, r);
    check("hole rdata", d, 32'h0);
    check("hole rresp", r, RESP_SLVERR);
    // position mode for both cylinder parities
    for (int ev = 0; ev < 2; ev++)
    begin
      axiWrite(REG_CTRL, 32'(ev * 2), r);
      for (int i = 0; i < 20; i++)
      begin
        e = pick(i);
        h = pick(19 - i);
        positionError <= e;
        headSignal <= h;
        repeat (2) @(posedge ref_clk);
        check("lin fwd", linear_forward_current, e > 0);
        check("lin rev", linear_reverse_current, e < 0);
        check("lowers", {lowerForward, lowerReverse}, {e > 0, e < 0});
        check("uppers", {upperForward, upperReverse, centerTap}, 3'h1);
        check("head out", headSignalOut, ev ? flipSig(h) : h);
      end
    end
    // velocity mode: every drive input pair, then random pairs
    axiWrite(REG_CTRL, 32'h1, r);
    for (int i = 0; i < 12; i++)
    begin
      k = (i < 4) ? i : $urandom_range(3);
      forward_drive_n <= k[0];
      reverse_drive_n <= k[1];
      fOn = !k[0] && k[1];
      rOn = k[0] && !k[1];
      repeat (2) @(posedge ref_clk);
      check("fwd pair", {upperForward, lowerForward}, {fOn, fOn});
      check("rev pair", {upperReverse, lowerReverse, centerTap}, {rOn, rOn, 1'b0});
    end
    // each trip cause from a fresh reset; timers get a near miss first
    for (int c = 0; c < 4; c++)
    begin
      nrst <= 1'b0;
      forward_drive_n <= 1'b1;
      reverse_drive_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      spindleUpToSpeed <= 1'($urandom_range(1));
      unpark <= 1'b1;
      @(posedge ref_clk);
      unpark <= 1'b0;
      if (c % 2 == 0)
      begin
        repeat (2)
        begin
          setCause(c, 1'b1);
          repeat ((c == 0 ? RW : OW) - 3) @(posedge ref_clk);
          setCause(c, 1'b0);
          @(posedge ref_clk);
        end
        repeat (3) @(posedge ref_clk);
        check("no early trip", retract_relay, 1'b0);
      end
      setCause(c, 1'b1);
      n = 0;
      while (!retract_relay && n < 100)
      begin
        @(posedge ref_clk);
        n++;
      end
      check("relay", retract_relay, 1'b1);
      check("bridge off", {upperForward, upperReverse, lowerForward, lowerReverse}, 4'h0);
      setCause(c, 1'b0);
      check("irq masked", irq, 1'b0);
      axiWrite(REG_MASK, 32'h1F, r);
      check("irq raised", irq, 1'b1);
      n = 0;
      while (!heads_retracted_switch && n < 300)
      begin
        @(posedge ref_clk);
        n++;
      end
      repeat (2) @(posedge ref_clk);
      check("drive parked", {retractDrive, retract_relay}, 2'h1);
      regChk("trip status", REG_STATUS, 32'h10 | (32'h1 << c));
      regChk("status read", REG_STATUS, 32'h0);
      check("irq cleared", irq, 1'b0);
      axiWrite(REG_STATE, 32'h0, r);
      regChk("state", REG_STATE, 32'h81);
    end
    finishTest();
  end

  // watchdog well beyond the few hundred cycles the sequence needs
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    errTotal++;
    finishTest();
  end
endmodule : svdr_steer_tb
